// ===== rtl/dummy_cycle_table.sv
/*
 * Read-only dummy-cycle discovery table behind an Avalon-MM slave.
 * Holds the variable dummy configuration word and the upper and middle
 * pattern words, plus a read-only word naming the shortest supported count.
 * Assumes a master that holds its request until waitrequest is low.
 */
`timescale 1ns/100ps
`default_nettype none
module dummy_cycle_table #(
   parameter logic VDC_SUP_P = 1'b1,
   parameter logic [1:0] NBITS_P = 2'h2,
   parameter logic [3:0] POS_P = 4'h4,
   parameter logic [29:0] UPPER_P = 30'h2AAA_AAAA,
   parameter logic [29:0] MIDDLE_P = 30'h1555_5555
) (
   input wire logic MCLK_I,
   input wire logic SYS_RST_I,
   input wire logic [3:0] AVS_ADDRESS_I,
   input wire logic AVS_READ_I,
   input wire logic AVS_WRITE_I,
   input wire logic [31:0] AVS_WRITEDATA_I,
   input wire logic [3:0] AVS_BYTEENABLE_I,
   output logic [31:0] AVS_READDATA_O,
   output logic AVS_WAITREQUEST_O
);
   dummy_cycle_pkg::vdc_cfg_s cfg;
   dummy_cycle_pkg::bus_state_e state_r, state_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [31:0] upper_w, middle_w, cfg_w, sel_w;
   logic [3:0] short_idx;

   ////////////////////////////////////////////////////////////////////////
   // Constant configuration description
   always_comb begin
      cfg.vdc_sup = VDC_SUP_P;
      cfg.nbits = NBITS_P;
      cfg.pos = POS_P;
      cfg_w = dummy_cycle_pkg::READ_UNMAPPED;
      cfg_w[dummy_cycle_pkg::CFG_SUP_BIT] = cfg.vdc_sup;
      cfg_w[dummy_cycle_pkg::CFG_NBITS_LSB +: 2] = cfg.nbits;
      cfg_w[dummy_cycle_pkg::CFG_POS_LSB +: 4] = cfg.pos;
   end

   // Both pattern words share one builder; it masks patterns by the count field only, never by support
   dummy_pattern_word #(.SLOTS_P(UPPER_P)) u_upper (
      .nbits_i(cfg.nbits),
      .word_o(upper_w)
   );
   dummy_pattern_word #(.SLOTS_P(MIDDLE_P)) u_middle (
      .nbits_i(cfg.nbits),
      .word_o(middle_w)
   );

   ////////////////////////////////////////////////////////////////////////
   // Shortest supported count as a slot index, 10 when none, so software
   // finds a legal choice without scanning both words
   always_comb begin
      short_idx = dummy_cycle_pkg::SEL_COUNT;
      for (int s = 0; s < 10; s++) begin
         if (s < 5) begin
            if (upper_w[31 - s*6] && cfg.vdc_sup) short_idx = 4'(s);
         end else begin
            if (middle_w[31 - (s-5)*6] && cfg.vdc_sup) short_idx = 4'(s);
         end
      end
      sel_w = {28'h0, short_idx};
   end

   ////////////////////////////////////////////////////////////////////////
   // Slave: request taken in idle, answered one cycle later; writes ignored
   always_comb begin
      state_nxt = state_r;
      rdata_nxt = rdata_r;
      case (state_r)
         dummy_cycle_pkg::ST_IDLE: begin
            if (AVS_READ_I || AVS_WRITE_I) begin
               state_nxt = dummy_cycle_pkg::ST_ANS;
               if (AVS_READ_I) begin
                  case (AVS_ADDRESS_I)
                     dummy_cycle_pkg::ADDR_VDC_CFG: rdata_nxt = cfg_w;
                     dummy_cycle_pkg::ADDR_UPPER: rdata_nxt = upper_w;
                     dummy_cycle_pkg::ADDR_MIDDLE: rdata_nxt = middle_w;
                     dummy_cycle_pkg::ADDR_SEL: rdata_nxt = sel_w;
                     default: rdata_nxt = dummy_cycle_pkg::READ_UNMAPPED;
                  endcase
               end
            end
         end
         dummy_cycle_pkg::ST_ANS: begin
            state_nxt = dummy_cycle_pkg::ST_IDLE;
         end
         default: state_nxt = dummy_cycle_pkg::ST_IDLE;
      endcase
   end

   // Only bus state and read data change on a read; table content is constant
   always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         state_r <= dummy_cycle_pkg::ST_IDLE;
         rdata_r <= 32'h0000_0000;
      end else begin
         state_r <= state_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign AVS_READDATA_O = rdata_r;
   assign AVS_WAITREQUEST_O = (AVS_READ_I || AVS_WRITE_I) &&
                              (state_r == dummy_cycle_pkg::ST_IDLE);

   ////////////////////////////////////////////////////////////////////////
   // Checks
   property p_up_res;
      @(posedge MCLK_I) disable iff (SYS_RST_I)
      (AVS_READ_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I == dummy_cycle_pkg::ADDR_UPPER)
      |-> AVS_READDATA_O[1:0] == 2'h0;
   endproperty
   a_up_res: assert property (p_up_res) else $error("upper reserved bits set");

   property p_mid_res;
      @(posedge MCLK_I) disable iff (SYS_RST_I)
      (AVS_READ_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I == dummy_cycle_pkg::ADDR_MIDDLE)
      |-> AVS_READDATA_O[1:0] == 2'h0;
   endproperty
   a_mid_res: assert property (p_mid_res) else $error("middle reserved bits set");

   property p_up_top;
      @(posedge MCLK_I) disable iff (SYS_RST_I)
      (AVS_READ_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I == dummy_cycle_pkg::ADDR_UPPER)
      |-> AVS_READDATA_O[31] == UPPER_P[29] && AVS_READDATA_O[7] == UPPER_P[5];
   endproperty
   a_up_top: assert property (p_up_top) else $error("upper flags wrong");

   property p_mid_flag;
      @(posedge MCLK_I) disable iff (SYS_RST_I)
      (AVS_READ_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I == dummy_cycle_pkg::ADDR_MIDDLE)
      |-> AVS_READDATA_O[25] == MIDDLE_P[23] && AVS_READDATA_O[13] == MIDDLE_P[11];
   endproperty
   a_mid_flag: assert property (p_mid_flag) else $error("middle flags wrong");

   property p_just;
      @(posedge MCLK_I) disable iff (SYS_RST_I)
      cfg.nbits != dummy_cycle_pkg::NBITS_5 |->
      {upper_w[30], upper_w[24], upper_w[18], upper_w[12], upper_w[6]} == 5'h00 &&
      {middle_w[30], middle_w[24], middle_w[18], middle_w[12], middle_w[6]} == 5'h00;
   endproperty
   a_just: assert property (p_just) else $error("pattern not right-justified");

   property p_cfg;
      @(posedge MCLK_I) disable iff (SYS_RST_I)
      (AVS_READ_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I == dummy_cycle_pkg::ADDR_VDC_CFG)
      |-> AVS_READDATA_O[31] == VDC_SUP_P && AVS_READDATA_O[28:27] == NBITS_P &&
      AVS_READDATA_O[26:23] == POS_P;
   endproperty
   a_cfg: assert property (p_cfg) else $error("configuration word wrong");

   property p_wait;
      @(posedge MCLK_I) disable iff (SYS_RST_I)
      $rose(AVS_READ_I) && state_r == dummy_cycle_pkg::ST_IDLE
      |-> AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O;
   endproperty
   a_wait: assert property (p_wait) else $error("answer not after one cycle");

   property p_stable;
      @(posedge MCLK_I) disable iff (SYS_RST_I)
      AVS_WRITE_I |=> $stable(upper_w) && $stable(middle_w);
   endproperty
   a_stable: assert property (p_stable) else $error("table changed");

   c_up: cover property (@(posedge MCLK_I) AVS_READ_I && !AVS_WAITREQUEST_O &&
      AVS_ADDRESS_I == dummy_cycle_pkg::ADDR_UPPER);
   c_mid: cover property (@(posedge MCLK_I) AVS_READ_I && !AVS_WAITREQUEST_O &&
      AVS_ADDRESS_I == dummy_cycle_pkg::ADDR_MIDDLE);
   c_wr: cover property (@(posedge MCLK_I) AVS_WRITE_I && !AVS_WAITREQUEST_O);
endmodule
`default_nettype wire

// ===== rtl/dummy_cycle_pkg.sv
/*
 * Package for the dummy-cycle pattern table: register indices, field layout,
 * the unmapped read value and the Avalon-MM slave state enumeration.
 * Assumes a 32-bit Avalon-MM bus with word addressing by byte address.
 */
package dummy_cycle_pkg;
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned PAT_W = 5;
   localparam int unsigned SLOTS = 5;
   localparam int unsigned SLOT_W = 6;
   localparam int unsigned SLOT0_TOP = 31;
   localparam int unsigned RSVD_W = 2;

   // Byte addresses of the words on the register bus
   localparam logic [3:0] ADDR_VDC_CFG = 4'h0;
   localparam logic [3:0] ADDR_UPPER = 4'h4;
   localparam logic [3:0] ADDR_MIDDLE = 4'h8;
   localparam logic [3:0] ADDR_SEL = 4'hC;

   // Variable dummy configuration word fields
   localparam int unsigned CFG_SUP_BIT = 31;
   localparam int unsigned CFG_NBITS_LSB = 27;
   localparam int unsigned CFG_POS_LSB = 23;
   localparam logic [1:0] NBITS_2 = 2'h0;
   localparam logic [1:0] NBITS_3 = 2'h1;
   localparam logic [1:0] NBITS_4 = 2'h2;
   localparam logic [1:0] NBITS_5 = 2'h3;
   localparam logic [2:0] NBITS_MIN = 3'h2;

   // Selection word fields
   localparam int unsigned SEL_IDX_W = 4;
   localparam logic [3:0] SEL_COUNT = 4'hA;

   localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

   // One slot: support flag and pattern
   typedef struct packed {
      logic sup;
      logic [4:0] pat;
   } slot_s;

   typedef struct packed {
      logic vdc_sup;
      logic [1:0] nbits;
      logic [3:0] pos;
   } vdc_cfg_s;

   // Slave states, Gray along idle -> answer
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_ANS = 2'h1
   } bus_state_e;
endpackage

// ===== rtl/dummy_pattern_word.sv
/*
 * One pattern word built from five support/pattern slots.
 * Assumes pattern inputs are static straps or constants.
 */
`timescale 1ns/100ps
`default_nettype none
module dummy_pattern_word #(
   parameter logic [29:0] SLOTS_P = 30'h0
) (
   input wire logic [1:0] nbits_i,
   output logic [31:0] word_o
);
   logic [31:0] w;

   // Keep only as many low pattern bits as the count field allows
   function automatic logic [4:0] pat_mask(input logic [1:0] nb);
      case (nb)
         dummy_cycle_pkg::NBITS_2: pat_mask = 5'h03;
         dummy_cycle_pkg::NBITS_3: pat_mask = 5'h07;
         dummy_cycle_pkg::NBITS_4: pat_mask = 5'h0F;
         default: pat_mask = 5'h1F;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Pack slots from bit 31 downward, two reserved bits at the bottom
   always_comb begin
      w = dummy_cycle_pkg::READ_UNMAPPED;
      for (int s = 0; s < dummy_cycle_pkg::SLOTS; s++) begin
         // Top slot lives at 31..26, each next six bits lower
         w[dummy_cycle_pkg::SLOT0_TOP - s*dummy_cycle_pkg::SLOT_W] =
            SLOTS_P[29 - s*6];
         w[(dummy_cycle_pkg::SLOT0_TOP - 1 - s*dummy_cycle_pkg::SLOT_W) -: 5] =
            SLOTS_P[(28 - s*6) -: 5] & pat_mask(nbits_i);
      end
      w[dummy_cycle_pkg::RSVD_W-1:0] = 2'h0;
   end
   assign word_o = w;
endmodule
`default_nettype wire

// ===== verif/dummy_cycle_host.sv
/*
 * Host model: an Avalon-MM master that reads the discovery words.
 * Assumes one command at a time, given while busy_o is low.
 */
`timescale 1ns/100ps
`default_nettype none
module dummy_cycle_host (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cmd_i,
   input wire logic cmd_wr_i,
   input wire logic [3:0] cmd_addr_i,
   input wire logic [31:0] cmd_data_i,
   input wire logic [31:0] rdata_i,
   input wire logic wait_i,
   output logic rd_o,
   output logic wr_o,
   output logic [3:0] addr_o,
   output logic [31:0] wdata_o,
   output logic busy_o,
   output logic rsp_o,
   output logic [31:0] rsp_data_o
);
   ////////////////////////////////////////////////////////////////////////////
   // Request held until waitrequest low; data taken at that edge only
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rd_o <= 1'b0;
         wr_o <= 1'b0;
         addr_o <= 4'h0;
         wdata_o <= 32'h0000_0000;
         busy_o <= 1'b0;
         rsp_o <= 1'b0;
         rsp_data_o <= 32'h0000_0000;
      end else begin
         rsp_o <= 1'b0;
         if (busy_o) begin
            if (!wait_i) begin
               rd_o <= 1'b0;
               wr_o <= 1'b0;
               busy_o <= 1'b0;
               rsp_o <= rd_o; // Only reads give a result
               rsp_data_o <= rdata_i;
            end
         end else if (cmd_i) begin
            // Writes here probe the read-only words; a real host never programs them
            rd_o <= !cmd_wr_i;
            wr_o <= cmd_wr_i;
            addr_o <= cmd_addr_i;
            wdata_o <= cmd_data_i;
            busy_o <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ===== verif/dummy_cycle_table_tb_top.sv
/*
 * Self-checking bench for the dummy-cycle table, driven through the host model.
 * Assumes the slave answers in its own time; only the timeout ends a wait.
 */
`timescale 1ns/100ps
`default_nettype none
module dummy_cycle_table_tb_top;
   localparam logic VDC = 1'b1;
   localparam logic [1:0] NB = 2'h1; // Three bits, so masking shows
   localparam logic [3:0] POS = 4'h6;
   localparam logic [29:0] UP = 30'h2F3C_5A69;
   localparam logic [29:0] MID = 30'h0D2B_4E17;
   logic clk = 1'b0, rst = 1'b1, cmd = 1'b0, cmd_wr = 1'b0, rd, wr, wreq, busy, rsp;
   logic [3:0] cmd_addr = 4'h0, addr, be = 4'hF;
   logic [31:0] cmd_data = 32'h0000_0000, wdata, rdata, rsp_data;
   logic [31:0] q[$];
   integer fails = 0, checked = 0, cycles = 0, seed = 32'h5413EAAF, i;
   always #25 clk = ~clk;
   dummy_cycle_table #(.VDC_SUP_P(VDC), .NBITS_P(NB), .POS_P(POS), .UPPER_P(UP),
      .MIDDLE_P(MID)) i_dummy_cycle_table (.MCLK_I(clk), .SYS_RST_I(rst),
      .AVS_ADDRESS_I(addr), .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata),
      .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wreq));
   dummy_cycle_host i_dummy_cycle_host (.clk_i(clk), .rst_i(rst), .cmd_i(cmd),
      .cmd_wr_i(cmd_wr), .cmd_addr_i(cmd_addr), .cmd_data_i(cmd_data), .rdata_i(rdata),
      .wait_i(wreq), .rd_o(rd), .wr_o(wr), .addr_o(addr), .wdata_o(wdata), .busy_o(busy),
      .rsp_o(rsp), .rsp_data_o(rsp_data));
   ////////////////////////////////////////////////////////////////////////////
   // Expected word from the table parameters, never from the design
   function automatic logic [31:0] exp_word(input logic [3:0] a);
      logic [29:0] m;
      logic [31:0] w;
      m = {5{1'b1, 5'((6'h01 << (NB + 3'h2)) - 6'h01)}}; // Unused high bits zero
      w = 32'h0000_0000;
      case (a)
         4'h0: w = {VDC, 2'b00, NB, POS, 23'h0};
         4'h4: w = {UP & m, 2'b00};
         4'h8: w = {MID & m, 2'b00};
         4'hC: begin
            w = 32'h0000_000A; // Longest-to-shortest scan, last flag wins
            for (int k = 0; k < 10; k++) begin
               if (VDC && (k < 5 ? UP[29 - 6 * k] : MID[29 - 6 * (k - 5)])) w = k;
            end
         end
         default: w = 32'h0000_0000;
      endcase
      return w;
   endfunction
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] e);
      checked++;
      if (seen !== e) begin
         fails++;
         $display("ERROR %s expected %h seen %h", name, e, seen);
      end
   endtask
   task automatic conclude();
      $display("Mismatches %0d, comparisons %0d", fails, checked);
      if (fails == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // One access through the host; reads note their expected word
   task automatic access(input logic w, input logic [3:0] a, input logic [31:0] d);
      if (!w) q.push_back(exp_word(a));
      cmd <= 1'b1;
      cmd_wr <= w;
      cmd_addr <= a;
      cmd_data <= d;
      @(posedge clk);
      cmd <= 1'b0;
      do @(posedge clk); while (busy !== 1'b0);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Result watcher: oldest note against each returned word
   always @(posedge clk) begin
      if (rsp === 1'b1) check("readdata", rsp_data, q.pop_front());
      cycles++;
      if (cycles == 4000) begin
         fails++;
         conclude();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Main sequence: every word, writes that must not stick, random traffic
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (i = 0; i < 16; i += 4) access(1'b0, 4'(i), 32'h0000_0000);
      access(1'b0, 4'h2, 32'h0000_0000); // Unmapped address
      for (i = 0; i < 16; i += 4) begin
         access(1'b1, 4'(i), 32'hFFFF_FFFF); // Writes leave the words unchanged
         access(1'b0, 4'(i), 32'h0000_0000);
      end
      for (i = 0; i < 60; i++) begin
         be <= 4'($random(seed));
         access(1'($random(seed)), 4'($random(seed)), $random(seed));
      end
      repeat (3) @(posedge clk);
      check("queue", 32'(q.size()), 32'h0000_0000);
      conclude();
   end
endmodule
`default_nettype wire
